//--- common/ird_defines.svh
// Register offsets, field positions, reset values and device numbers
//
// Overview of operation
// R1 - Four-bit interrupt level per device: zero is none, 1..15 select IRQ1..IRQ15.
// R2 - Pin interrupts are active-high edges, except parallel port in ECP/EPP modes.
// R3 - Chosen level drives both the serial IRQ vector and the ISA pins.
// R4 - Software must program parallel config-B shadow IRQ/DMA bits separately.
// R5 - Both serial ports may share one interrupt pin when configured.
// R6 - Floppy interrupt needs nonzero level and the floppy DMA gate set.
// R7 - Parallel interrupt needs level, port enable, and clear ECP service bit; the code skips the port enable in FIFO, ECP and test modes.
// R8 - Serial interrupt needs level, any enable bit 0..3, and aux output two.
// R9 - Interrupt pins float when no device selects or uses them.
// R10 - Three-bit DMA select: 0..3 pick a channel, 4..7 pick none.
// R11 - DMA channel active only with valid select and owning device's enable.
// R12 - DMA request pins float when no device selects or uses them.
// R13 - Inactive, out-of-range or unselected devices lose interrupt and acknowledge.
// R14 - Floppy gate clear or power down floats interrupt and acknowledge.
// R15 - First serial interrupt floats while its aux output two is clear.
// R16 - Second serial interrupt floats while its aux output two is clear.
// R17 - Second serial DMA request floats unless enabled; then low until requesting.
// R18 - Parallel interrupt gating per mode; parallel DMA always by ECP enable.
// R19 - Select registers read back as written and take effect immediately.
`ifndef IRD_DEFINES_SVH
`define IRD_DEFINES_SVH

`define IRD_OFS_DEV_NUM 8'h07
`define IRD_OFS_ACTIVATE 8'h30
`define IRD_OFS_IRQ_LEVEL 8'h70
`define IRD_OFS_DMA_CHAN 8'h74
`define IRD_OFS_SHARE 8'hF0

`define IRD_LDN_FLOPPY 8'h00
`define IRD_LDN_PARALLEL 8'h03
`define IRD_LDN_SERIAL1 8'h04
`define IRD_LDN_SERIAL2 8'h05

`define IRD_ACT_BIT 0
`define IRD_SHARE_BIT 0
`define IRD_DMA_NONE_BIT 2

`define IRD_RST_LDN 8'h00
`define IRD_RST_IRQ_LEVEL 4'h0
`define IRD_RST_DMA_CHAN 3'h4

`endif

//--- common/ird_pkg.sv
// Types shared by the interrupt and DMA router
package ird_pkg;
    typedef logic [3:0] ird_irq_lvl_t;
    typedef logic [2:0] ird_dma_sel_t;
    typedef enum logic [2:0] {
        IRD_PM_PRINTER = 3'h0,
        IRD_PM_SPP = 3'h1,
        IRD_PM_FIFO = 3'h2,
        IRD_PM_ECP = 3'h3,
        IRD_PM_EPP = 3'h4,
        IRD_PM_RES = 3'h5,
        IRD_PM_TEST = 3'h6,
        IRD_PM_CONFIG = 3'h7
    } ird_par_mode_t;
    typedef enum logic [1:0] {
        IRD_DEV_FLOPPY,
        IRD_DEV_PARALLEL,
        IRD_DEV_SERIAL1,
        IRD_DEV_SERIAL2
    } ird_dev_t;
endpackage

//--- design/ird_router.sv
// Interrupt level and DMA channel routing for four logical devices
//
// Local design decision: the address-and-strobe port.
`include "ird_defines.svh"

module ird_router import ird_pkg::*; (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic [3:0] ADDR_IN_RANGE,
    input wire logic [3:0] DEV_IRQ_REQ,
    input wire logic [3:0] DEV_DMA_REQ,
    input wire logic FLOPPY_DMA_GATE,
    input wire logic FLOPPY_POWER_DOWN,
    input wire logic PORT_INTERRUPT_ENABLE,
    input wire logic ECP_SERVICE_INTERRUPT_MASK,
    input wire logic ECP_DMA_ENABLE_BIT,
    input wire logic [2:0] PARALLEL_MODE,
    input wire logic [3:0] SERIAL1_INTERRUPT_ENABLE_REG,
    input wire logic SERIAL1_MODEM_AUX_OUTPUT_TWO,
    input wire logic [3:0] SERIAL2_INTERRUPT_ENABLE_REG,
    input wire logic SERIAL2_MODEM_AUX_OUTPUT_TWO,
    input wire logic SERIAL2_CFG_B_DMA_ENABLE,
    input wire logic [3:0] DMA_ACKNOWLEDGE_N,
    output logic [15:0] IRQ_OUT,
    output logic [15:0] IRQ_OE,
    output logic [15:0] SERIAL_IRQ_LEVELS,
    output logic [3:0] DMA_REQUEST_PIN_OUT,
    output logic [3:0] DMA_REQUEST_PIN_OE,
    output logic [3:0] DEV_DMA_ACK_N
);

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic [7:0] ldn_q;
    ird_irq_lvl_t irq_lvl_q [4];
    ird_dma_sel_t dma_sel_q [4];
    logic [3:0] act_q;
    logic share_q;

    wire dev_hit = (ldn_q == `IRD_LDN_FLOPPY) ||
                   (ldn_q == `IRD_LDN_PARALLEL) ||
                   (ldn_q == `IRD_LDN_SERIAL1) ||
                   (ldn_q == `IRD_LDN_SERIAL2);
    wire [1:0] dev_idx = (ldn_q == `IRD_LDN_PARALLEL) ? 2'h1 :
                         (ldn_q == `IRD_LDN_SERIAL1) ? 2'h2 :
                         (ldn_q == `IRD_LDN_SERIAL2) ? 2'h3 : 2'h0;
    wire wr_ldn = REG_WR && (REG_ADDR == `IRD_OFS_DEV_NUM);
    wire wr_dev = REG_WR && dev_hit;
    wire wr_act = wr_dev && (REG_ADDR == `IRD_OFS_ACTIVATE);
    wire wr_irq = wr_dev && (REG_ADDR == `IRD_OFS_IRQ_LEVEL);
    wire wr_dma = wr_dev && (REG_ADDR == `IRD_OFS_DMA_CHAN);
    wire wr_share = wr_dev && (REG_ADDR == `IRD_OFS_SHARE) &&
                    (dev_idx == 2'(IRD_DEV_SERIAL1));

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ldn_q <= `IRD_RST_LDN;
            share_q <= 1'b0;
        end else begin
            if (wr_ldn) begin
                ldn_q <= REG_WDATA;
            end
            if (wr_share) begin
                share_q <= REG_WDATA[`IRD_SHARE_BIT]; // [R5]
            end
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_cfg
        wire sel = (dev_idx == 2'(g));
        always_ff @(posedge CLK or negedge RST_B) begin
            if (!RST_B) begin
                irq_lvl_q[g] <= `IRD_RST_IRQ_LEVEL;
                dma_sel_q[g] <= `IRD_RST_DMA_CHAN;
                act_q[g] <= 1'b0;
            end else begin
                if (wr_irq && sel) begin
                    irq_lvl_q[g] <= REG_WDATA[3:0]; // [R1] [R19]
                end
                if (wr_dma && sel) begin
                    dma_sel_q[g] <= REG_WDATA[2:0]; // [R10] [R19]
                end
                if (wr_act && sel) begin
                    act_q[g] <= REG_WDATA[`IRD_ACT_BIT];
                end
            end
        end
    end

    // Read data for the cycle after the strobe; unmapped reads give zero
    wire [7:0] rd_d =
        (REG_ADDR == `IRD_OFS_DEV_NUM) ? ldn_q :
        !dev_hit ? 8'h00 :
        (REG_ADDR == `IRD_OFS_ACTIVATE) ? {7'h00, act_q[dev_idx]} :
        (REG_ADDR == `IRD_OFS_IRQ_LEVEL) ? {4'h0, irq_lvl_q[dev_idx]} :
        (REG_ADDR == `IRD_OFS_DMA_CHAN) ? {5'h00, dma_sel_q[dev_idx]} :
        ((REG_ADDR == `IRD_OFS_SHARE) &&
         (dev_idx == 2'(IRD_DEV_SERIAL1))) ? {7'h00, share_q} : 8'h00;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= 8'h00;
        end else begin
            REG_RDATA <= REG_RD ? rd_d : 8'h00; // [R19]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-device enables

    wire [3:0] base_ok = act_q & ADDR_IN_RANGE; // [R13]
    ird_irq_lvl_t eff_lvl [4];
    assign eff_lvl[0] = irq_lvl_q[0];
    assign eff_lvl[1] = irq_lvl_q[1];
    assign eff_lvl[2] = irq_lvl_q[2];
    // Shared mode puts the second serial port on the first one's pin
    assign eff_lvl[3] = share_q ? irq_lvl_q[2] : irq_lvl_q[3]; // [R5]

    wire [3:0] lvl_ok = {eff_lvl[3] != 4'h0, eff_lvl[2] != 4'h0,
                         eff_lvl[1] != 4'h0, eff_lvl[0] != 4'h0}; // [R1]
    wire [3:0] chan_ok = {~dma_sel_q[3][`IRD_DMA_NONE_BIT],
                          ~dma_sel_q[2][`IRD_DMA_NONE_BIT],
                          ~dma_sel_q[1][`IRD_DMA_NONE_BIT],
                          ~dma_sel_q[0][`IRD_DMA_NONE_BIT]}; // [R10]

    ird_par_mode_t par_mode;
    assign par_mode = ird_par_mode_t'(PARALLEL_MODE);
    wire par_irq_on = (par_mode == IRD_PM_FIFO) ||
                      (par_mode == IRD_PM_ECP) ||
                      (par_mode == IRD_PM_TEST); // [R18]
    wire par_ecp = (par_mode == IRD_PM_ECP);
    // ECP and EPP requests leave the pin active low
    wire par_low = par_ecp || (par_mode == IRD_PM_EPP); // [R2]
    wire floppy_live = FLOPPY_DMA_GATE && !FLOPPY_POWER_DOWN; // [R14]

    wire [3:0] irq_dev_en;
    assign irq_dev_en[0] = base_ok[0] && lvl_ok[0] && floppy_live; // [R6]
    assign irq_dev_en[1] = base_ok[1] && lvl_ok[1] &&
                           (par_irq_on || PORT_INTERRUPT_ENABLE) &&
                           !(par_ecp && ECP_SERVICE_INTERRUPT_MASK); // [R7]
    assign irq_dev_en[2] = base_ok[2] && lvl_ok[2] &&
                           (|SERIAL1_INTERRUPT_ENABLE_REG) &&
                           SERIAL1_MODEM_AUX_OUTPUT_TWO; // [R8] [R15]
    assign irq_dev_en[3] = base_ok[3] && lvl_ok[3] &&
                           (|SERIAL2_INTERRUPT_ENABLE_REG) &&
                           SERIAL2_MODEM_AUX_OUTPUT_TWO; // [R8] [R16]

    wire [3:0] dma_dev_en;
    assign dma_dev_en[0] = base_ok[0] && chan_ok[0] && floppy_live; // [R11]
    assign dma_dev_en[1] = base_ok[1] && chan_ok[1] &&
                           ECP_DMA_ENABLE_BIT; // [R11] [R18]
    // The first serial port has no DMA engine
    assign dma_dev_en[2] = 1'b0;
    assign dma_dev_en[3] = base_ok[3] && chan_ok[3] &&
                           SERIAL2_CFG_B_DMA_ENABLE; // [R11] [R17]

    wire [3:0] irq_val = DEV_IRQ_REQ ^ {2'b00, par_low, 1'b0}; // [R2]

    ////////////////////////////////////////////////////////////////////////
    // Pin routing

    logic [15:0] irq_out_d;
    logic [15:0] irq_oe_d;
    logic [15:0] sirq_d;
    for (genvar k = 0; k < 16; k++) begin : g_irq
        wire [3:0] hit = {eff_lvl[3] == 4'(k), eff_lvl[2] == 4'(k),
                          eff_lvl[1] == 4'(k), eff_lvl[0] == 4'(k)};
        assign irq_oe_d[k] = |(hit & irq_dev_en); // [R9]
        assign irq_out_d[k] = |(hit & irq_dev_en & irq_val); // [R3]
        assign sirq_d[k] = |(hit & irq_dev_en & DEV_IRQ_REQ); // [R3]
    end

    logic [3:0] ack_meta_q;
    logic [3:0] ack_sync_q;
    logic [3:0] drq_out_d;
    logic [3:0] drq_oe_d;
    logic [3:0] dack_n_d;
    for (genvar c = 0; c < 4; c++) begin : g_dma
        wire [3:0] hit = {dma_sel_q[3] == {1'b0, 2'(c)},
                          dma_sel_q[2] == {1'b0, 2'(c)},
                          dma_sel_q[1] == {1'b0, 2'(c)},
                          dma_sel_q[0] == {1'b0, 2'(c)}};
        assign drq_oe_d[c] = |(hit & dma_dev_en); // [R12]
        // Driven low while idle, high while the owner requests
        assign drq_out_d[c] = |(hit & dma_dev_en & DEV_DMA_REQ); // [R17]
        // Disabled devices never see an acknowledge
        assign dack_n_d[c] = ~(dma_dev_en[c] &&
                              !ack_sync_q[dma_sel_q[c][1:0]]); // [R13] [R14]
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ack_meta_q <= 4'hF;
            ack_sync_q <= 4'hF;
        end else begin
            ack_meta_q <= DMA_ACKNOWLEDGE_N;
            ack_sync_q <= ack_meta_q;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            IRQ_OUT <= 16'h0000;
            IRQ_OE <= 16'h0000;
            SERIAL_IRQ_LEVELS <= 16'h0000;
            DMA_REQUEST_PIN_OUT <= 4'h0;
            DMA_REQUEST_PIN_OE <= 4'h0;
            DEV_DMA_ACK_N <= 4'hF;
        end else begin
            IRQ_OUT <= irq_out_d;
            IRQ_OE <= irq_oe_d;
            SERIAL_IRQ_LEVELS <= sirq_d;
            DMA_REQUEST_PIN_OUT <= drq_out_d;
            DMA_REQUEST_PIN_OE <= drq_oe_d;
            DEV_DMA_ACK_N <= dack_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    level_readback_a: assert property ( // [R19]
        @(posedge CLK) disable iff (!RST_B)
        wr_irq |=> irq_lvl_q[$past(dev_idx)] == $past(REG_WDATA[3:0]))
        else $error("interrupt level not stored");

    irq_idle_float_a: assert property ( // [R9]
        @(posedge CLK) disable iff (!RST_B)
        (lvl_ok == 4'h0) |=> (IRQ_OE == 16'h0000))
        else $error("interrupt pin driven with no level selected");

    floppy_gate_a: assert property ( // [R14]
        @(posedge CLK) disable iff (!RST_B)
        !FLOPPY_DMA_GATE |=> DEV_DMA_ACK_N[0])
        else $error("floppy acknowledge with gate clear");

    dma_none_a: assert property ( // [R12]
        @(posedge CLK) disable iff (!RST_B)
        (chan_ok == 4'h0) |=> (DMA_REQUEST_PIN_OE == 4'h0))
        else $error("DMA pin driven with no channel selected");

    serial2_drq_a: assert property ( // [R17]
        @(posedge CLK) disable iff (!RST_B)
        dma_dev_en[3] |=> DMA_REQUEST_PIN_OE[$past(dma_sel_q[3][1:0])] &&
            (DMA_REQUEST_PIN_OUT[$past(dma_sel_q[3][1:0])] ||
             !$past(DEV_DMA_REQ[3])))
        else $error("second serial DMA pin not driven");

    floppy_irq_pin_a: assert property ( // [R3]
        @(posedge CLK) disable iff (!RST_B)
        (irq_dev_en[0] && DEV_IRQ_REQ[0]) |=>
            IRQ_OUT[$past(irq_lvl_q[0])] &&
            SERIAL_IRQ_LEVELS[$past(irq_lvl_q[0])])
        else $error("floppy request not routed");

    serial1_modem_aux_output_two_a: assert property ( // [R15]
        @(posedge CLK) disable iff (!RST_B)
        (!SERIAL1_MODEM_AUX_OUTPUT_TWO && (irq_dev_en & 4'hB) == 4'h0) |=>
            (IRQ_OE == 16'h0000))
        else $error("first serial interrupt driven with aux two clear");

    par_mode_on_a: assert property ( // [R18]
        @(posedge CLK) disable iff (!RST_B)
        (par_mode == IRD_PM_FIFO && base_ok[1] && lvl_ok[1]) |=>
            IRQ_OE[$past(irq_lvl_q[1])])
        else $error("parallel interrupt not always on in fifo mode");

    shared_pin_a: assert property ( // [R5]
        @(posedge CLK) disable iff (!RST_B)
        (share_q && irq_dev_en[3] && DEV_IRQ_REQ[3]) |=>
            SERIAL_IRQ_LEVELS[$past(irq_lvl_q[2])])
        else $error("shared serial interrupt not on common level");

    inactive_dack_a: assert property ( // [R13]
        @(posedge CLK) disable iff (!RST_B)
        !act_q[1] |=> DEV_DMA_ACK_N[1] && !DMA_REQUEST_PIN_OE[$past(
            dma_sel_q[1][1:0])] || $past(dma_dev_en[0] || dma_dev_en[3]))
        else $error("inactive parallel port still acknowledged");

    ////////////////////////////////////////////////////////////////////////
    // Per-device gating seen at the pins, then polarity, routing and readback checks

    par_svc_mask_a: assert property ( // [R7]
        @(posedge CLK) disable iff (!RST_B)
        (par_ecp && ECP_SERVICE_INTERRUPT_MASK &&
         (irq_dev_en & 4'hD) == 4'h0) |=> (IRQ_OE == 16'h0000))
        else $error("parallel interrupt driven with service bit set");

    par_ie_gate_a: assert property ( // [R18]
        @(posedge CLK) disable iff (!RST_B)
        (!par_irq_on && !PORT_INTERRUPT_ENABLE &&
         (irq_dev_en & 4'hD) == 4'h0) |=> (IRQ_OE == 16'h0000))
        else $error("parallel interrupt driven with port enable clear");

    serial2_modem_aux_output_two_a: assert property ( // [R16]
        @(posedge CLK) disable iff (!RST_B)
        (!SERIAL2_MODEM_AUX_OUTPUT_TWO && (irq_dev_en & 4'h7) == 4'h0) |=>
            (IRQ_OE == 16'h0000))
        else $error("second serial interrupt driven with aux two clear");

    serial_ier_a: assert property ( // [R8]
        @(posedge CLK) disable iff (!RST_B)
        (SERIAL1_INTERRUPT_ENABLE_REG == 4'h0 &&
         (irq_dev_en & 4'hB) == 4'h0) |=> (IRQ_OE == 16'h0000))
        else $error("first serial interrupt driven with no enable bit");

    floppy_power_a: assert property ( // [R14]
        @(posedge CLK) disable iff (!RST_B)
        (FLOPPY_POWER_DOWN && (irq_dev_en & 4'hE) == 4'h0) |=>
            (IRQ_OE == 16'h0000) && DEV_DMA_ACK_N[0])
        else $error("floppy interrupt driven while powered down");

    floppy_irq_gate_a: assert property ( // [R6]
        @(posedge CLK) disable iff (!RST_B)
        (!FLOPPY_DMA_GATE && (irq_dev_en & 4'hE) == 4'h0) |=>
            (IRQ_OE == 16'h0000))
        else $error("floppy interrupt driven with gate clear");

    serial2_drq_off_a: assert property ( // [R17]
        @(posedge CLK) disable iff (!RST_B)
        (!SERIAL2_CFG_B_DMA_ENABLE && (dma_dev_en & 4'h3) == 4'h0) |=>
            (DMA_REQUEST_PIN_OE == 4'h0))
        else $error("second serial DMA pin driven while disabled");

    range_gate_a: assert property ( // [R13]
        @(posedge CLK) disable iff (!RST_B)
        (!ADDR_IN_RANGE[0] && (irq_dev_en & 4'hE) == 4'h0 &&
         (dma_dev_en & 4'hE) == 4'h0) |=>
            (IRQ_OE == 16'h0000) && (DMA_REQUEST_PIN_OE == 4'h0) &&
            DEV_DMA_ACK_N[0])
        else $error("floppy routed with address out of range");

    ecp_polarity_a: assert property ( // [R2]
        @(posedge CLK) disable iff (!RST_B)
        (irq_dev_en == 4'h2 && par_low && DEV_IRQ_REQ[1]) |=>
            !IRQ_OUT[$past(irq_lvl_q[1])])
        else $error("extended parallel request not driven low");

    edge_high_a: assert property ( // [R2]
        @(posedge CLK) disable iff (!RST_B)
        (irq_dev_en[2] && DEV_IRQ_REQ[2]) |=> IRQ_OUT[$past(eff_lvl[2])])
        else $error("serial request not driven high");

    dma_owner_a: assert property ( // [R11]
        @(posedge CLK) disable iff (!RST_B)
        (dma_dev_en[0] && DEV_DMA_REQ[0]) |=>
            DMA_REQUEST_PIN_OUT[$past(dma_sel_q[0][1:0])])
        else $error("floppy DMA request not routed");

    dma_ack_route_a: assert property ( // [R13]
        @(posedge CLK) disable iff (!RST_B)
        (dma_dev_en[3] && !ack_sync_q[dma_sel_q[3][1:0]]) |=>
            !DEV_DMA_ACK_N[3])
        else $error("second serial acknowledge not passed on");

    rdata_idle_a: assert property ( // [R19]
        @(posedge CLK) disable iff (!RST_B)
        !REG_RD |=> (REG_RDATA == 8'h00))
        else $error("read data present without a read");

    dma_readback_a: assert property ( // [R19]
        @(posedge CLK) disable iff (!RST_B)
        wr_dma |=> dma_sel_q[$past(dev_idx)] == $past(REG_WDATA[2:0]))
        else $error("DMA select not stored");

    level_select_a: assert property ( // [R1]
        @(posedge CLK) disable iff (!RST_B)
        (irq_dev_en == 4'h1) |=>
            (IRQ_OE == (16'h0001 << $past(irq_lvl_q[0]))))
        else $error("floppy interrupt on wrong level");

    dma_select_a: assert property ( // [R10]
        @(posedge CLK) disable iff (!RST_B)
        (dma_dev_en == 4'h1) |=>
            (DMA_REQUEST_PIN_OE == (4'h1 << $past(dma_sel_q[0][1:0]))))
        else $error("floppy DMA on wrong channel");

endmodule

//--- verification/ird_host_model.sv
// Host DMA controller model that acknowledges routed channel requests
module ird_host_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] dreq,
    input wire logic [3:0] dreq_oe,
    output logic [3:0] dack_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // A floating request pin is idle for the host, never a request
    wire [3:0] seen = dreq & dreq_oe;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dack_n <= 4'hF;
        end else begin
            dack_n <= ~seen;
        end
    end
endmodule

//--- verification/ird_router_bench.sv
// Self-checking bench for the interrupt and DMA router
`include "ird_defines.svh"
module ird_router_bench import ird_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] dev;
        logic [3:0] lvl;
        logic [2:0] dsel;
        logic [2:0] mode;
        logic [7:0] g;
        logic ei;
        logic ed;
    } ird_row_t;
    localparam int NROW = 24;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [3:0] rng = 4'hF;
    logic [3:0] irq_req = 4'hF;
    logic [3:0] dma_req = 4'hF;
    logic [7:0] g = 8'h00;
    logic [2:0] mode = 3'h0;
    logic [7:0] rdata, v;
    logic [15:0] irq_out, irq_oe, sirq, eo;
    logic [3:0] dq, dq_oe, ack_n, dack_n, ed4;
    logic inv;
    ird_row_t r;
    int bad_count = 0;
    int cmp_count = 0;
    logic [7:0] ldn [4] = '{`IRD_LDN_FLOPPY, `IRD_LDN_PARALLEL,
        `IRD_LDN_SERIAL1, `IRD_LDN_SERIAL2};
    // g: 0 gate, 1 power down, 2 port ie, 3 svc, 4 ecp dma, 5 aux2, 6 ier
    ird_row_t rows [NROW] = '{
        '{2'h0, 4'h6, 3'h1, 3'h0, 8'h01, 1'b1, 1'b1},
        '{2'h0, 4'h6, 3'h1, 3'h0, 8'h00, 1'b0, 1'b0},
        '{2'h0, 4'h6, 3'h1, 3'h0, 8'h03, 1'b0, 1'b0},
        '{2'h0, 4'h0, 3'h4, 3'h0, 8'h01, 1'b0, 1'b0},
        '{2'h0, 4'hF, 3'h3, 3'h0, 8'h01, 1'b1, 1'b1},
        '{2'h0, 4'h6, 3'h5, 3'h0, 8'h01, 1'b1, 1'b0},
        '{2'h1, 4'h7, 3'h0, 3'h0, 8'h10, 1'b0, 1'b1},
        '{2'h1, 4'h7, 3'h0, 3'h1, 8'h10, 1'b0, 1'b1},
        '{2'h1, 4'h7, 3'h0, 3'h2, 8'h10, 1'b1, 1'b1},
        '{2'h1, 4'h7, 3'h0, 3'h3, 8'h10, 1'b1, 1'b1},
        '{2'h1, 4'h7, 3'h0, 3'h4, 8'h10, 1'b0, 1'b1},
        '{2'h1, 4'h7, 3'h0, 3'h5, 8'h10, 1'b0, 1'b1},
        '{2'h1, 4'h7, 3'h0, 3'h6, 8'h10, 1'b1, 1'b1},
        '{2'h1, 4'h7, 3'h0, 3'h7, 8'h10, 1'b0, 1'b1},
        '{2'h1, 4'h7, 3'h0, 3'h1, 8'h14, 1'b1, 1'b1},
        '{2'h1, 4'h7, 3'h0, 3'h3, 8'h18, 1'b0, 1'b1},
        '{2'h1, 4'h7, 3'h0, 3'h4, 8'h04, 1'b1, 1'b0},
        '{2'h2, 4'h4, 3'h7, 3'h0, 8'h60, 1'b1, 1'b0},
        '{2'h2, 4'h4, 3'h7, 3'h0, 8'h40, 1'b0, 1'b0},
        '{2'h2, 4'h4, 3'h7, 3'h0, 8'h20, 1'b0, 1'b0},
        '{2'h3, 4'h3, 3'h2, 3'h0, 8'hE0, 1'b1, 1'b1},
        '{2'h3, 4'h3, 3'h2, 3'h0, 8'h60, 1'b1, 1'b0},
        '{2'h3, 4'h3, 3'h2, 3'h0, 8'hC0, 1'b0, 1'b1},
        '{2'h3, 4'h1, 3'h0, 3'h0, 8'hA0, 1'b0, 1'b1}
    };
    ird_router i_dut (.CLK(clk), .RST_B(rst_b), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata),
        .ADDR_IN_RANGE(rng), .DEV_IRQ_REQ(irq_req), .DEV_DMA_REQ(dma_req),
        .FLOPPY_DMA_GATE(g[0]), .FLOPPY_POWER_DOWN(g[1]),
        .PORT_INTERRUPT_ENABLE(g[2]), .ECP_SERVICE_INTERRUPT_MASK(g[3]),
        .ECP_DMA_ENABLE_BIT(g[4]), .PARALLEL_MODE(mode),
        .SERIAL1_INTERRUPT_ENABLE_REG(g[6] ? 4'h8 : 4'h0),
        .SERIAL1_MODEM_AUX_OUTPUT_TWO(g[5]),
        .SERIAL2_INTERRUPT_ENABLE_REG({3'h0, g[6]}),
        .SERIAL2_MODEM_AUX_OUTPUT_TWO(g[5]), .SERIAL2_CFG_B_DMA_ENABLE(g[7]),
        .DMA_ACKNOWLEDGE_N(dack_n), .IRQ_OUT(irq_out), .IRQ_OE(irq_oe),
        .SERIAL_IRQ_LEVELS(sirq), .DMA_REQUEST_PIN_OUT(dq),
        .DMA_REQUEST_PIN_OE(dq_oe), .DEV_DMA_ACK_N(ack_n));
    ird_host_model i_host (.clk(clk), .rst_b(rst_b), .dreq(dq),
        .dreq_oe(dq_oe), .dack_n(dack_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic cfg(input logic [1:0] dv, input logic [3:0] l,
        input logic [2:0] ds);
        wr(`IRD_OFS_DEV_NUM, ldn[dv]);
        wr(`IRD_OFS_ACTIVATE, 8'h01);
        wr(`IRD_OFS_IRQ_LEVEL, {4'h0, l});
        wr(`IRD_OFS_DMA_CHAN, {5'h00, ds});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always #5 clk = ~clk;
    // Whole run is about 700 cycles; this cuts a hang short
    initial begin
        #100000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd(`IRD_OFS_IRQ_LEVEL, v);
        chk({8'h00, v}, 16'h0000);
        rd(`IRD_OFS_DMA_CHAN, v);
        chk({8'h00, v}, 16'h0004);
        tick(1);
        chk({8'h00, rdata}, 16'h0000);
        rd(8'h55, v);
        chk({8'h00, v}, 16'h0000);
        wr(`IRD_OFS_DEV_NUM, 8'h02);
        wr(`IRD_OFS_IRQ_LEVEL, 8'h09);
        rd(`IRD_OFS_IRQ_LEVEL, v);
        chk({8'h00, v}, 16'h0000);
        for (int i = 0; i < NROW; i++) begin
            r = rows[i];
            @(posedge clk);
            g <= r.g;
            mode <= r.mode;
            cfg(r.dev, r.lvl, r.dsel);
            rd(`IRD_OFS_IRQ_LEVEL, v);
            chk({8'h00, v}, {12'h000, r.lvl});
            rd(`IRD_OFS_DMA_CHAN, v);
            chk({8'h00, v}, {13'h0000, r.dsel});
            tick(6);
            eo = r.ei ? 16'h0001 << r.lvl : 16'h0000;
            ed4 = r.ed ? 4'h1 << r.dsel : 4'h0;
            inv = r.dev == IRD_DEV_PARALLEL &&
                (r.mode == IRD_PM_ECP || r.mode == IRD_PM_EPP);
            chk(irq_oe, eo);
            chk(sirq, eo);
            chk(irq_out & irq_oe, inv ? 16'h0000 : eo);
            chk({12'h000, dq_oe}, {12'h000, ed4});
            chk({12'h000, dq & dq_oe}, {12'h000, ed4});
            chk({15'h0000, ack_n[r.dev]}, {15'h0000, ~r.ed});
            wr(`IRD_OFS_ACTIVATE, 8'h00);
            tick(3);
            chk(irq_oe, 16'h0000);
            chk({12'h000, dq_oe}, 16'h0000);
        end
        cfg(2'h0, 4'h6, 3'h1);
        @(posedge clk);
        g <= 8'h01;
        rng <= 4'hE;
        tick(4);
        chk(irq_oe, 16'h0000);
        @(posedge clk);
        rng <= 4'hF;
        tick(4);
        chk(irq_oe, 16'h0040);
        wr(`IRD_OFS_ACTIVATE, 8'h00);
        cfg(2'h3, 4'h3, 3'h2);
        @(posedge clk);
        g <= 8'hE0;
        dma_req <= 4'h0;
        tick(4);
        chk({12'h000, dq_oe}, 16'h0004);
        chk({12'h000, dq}, 16'h0000);
        @(posedge clk);
        dma_req <= 4'hF;
        tick(3);
        chk({12'h000, dq}, 16'h0004);
        cfg(2'h2, 4'h5, 3'h7);
        wr(`IRD_OFS_SHARE, 8'h01);
        wr(`IRD_OFS_DEV_NUM, `IRD_LDN_SERIAL2);
        wr(`IRD_OFS_IRQ_LEVEL, 8'h09);
        tick(3);
        chk(irq_oe, 16'h0020);
        wr(`IRD_OFS_DEV_NUM, `IRD_LDN_PARALLEL);
        wr(`IRD_OFS_IRQ_LEVEL, 8'h07);
        rd(8'hF1, v);
        chk({8'h00, v}, 16'h0000);
        @(posedge clk);
        rst_b <= 1'b0;
        tick(2);
        chk(irq_oe, 16'h0000);
        chk({12'h000, ack_n}, 16'h000F);
        @(posedge clk);
        rst_b <= 1'b1;
        rd(`IRD_OFS_IRQ_LEVEL, v);
        chk({8'h00, v}, 16'h0000);
        tally_and_finish();
    end
endmodule
